// [rtl/aisc_pkg.sv]
package aisc_pkg;

    // ************************************************************
    // Sizes and value format
    // ************************************************************
    localparam int NCURVE = 10;
    localparam int NPTS = 20;
    localparam int NSRC = 48;
    localparam int VW = 44;
    localparam int WW = 2 * VW;
    // Fixed point: one unit is 0.00001
    localparam logic signed [VW-1:0] SCALE = 44'h000000186a0;
    localparam logic signed [VW-1:0] HALF = 44'h0000000c350;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int UPD_STEP_NS = 5000000;
    localparam int TICK_CYC = UPD_STEP_NS / CLK_PERIOD_NS;
    localparam logic [10:0] CYC_DEF = 11'h01e;
    localparam logic [19:0] TAU_DEF = 20'h000c8;
    localparam logic [5:0] SRC_DEF = 6'h00;

    // ************************************************************
    // Types
    // ************************************************************
    typedef logic signed [VW-1:0] aisc_val_t;
    typedef logic signed [WW-1:0] aisc_wide_t;
    typedef enum logic [1:0] {
        RND_FLOAT = 2'h0,
        RND_FLOOR = 2'h1,
        RND_CEIL = 2'h2,
        RND_NEAR = 2'h3
    } aisc_rnd_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_LOAD = 3'h1,
        ST_SEG = 3'h3,
        ST_FIX = 3'h2,
        ST_CALC = 3'h6
    } aisc_st_t;

    typedef struct packed {
        logic en;
        logic [5:0] src;
        logic filt_en;
        logic [19:0] tau;
        logic rng_en;
        aisc_val_t in_min;
        aisc_val_t in_max;
        logic [10:0] cyc;
        aisc_rnd_t rnd;
        logic [NPTS-1:0] used;
        aisc_val_t [NPTS-1:0] px;
        aisc_val_t [NPTS-1:0] py;
    } aisc_cfg_t;

    localparam aisc_cfg_t CFG_DEF = '{
        en: 1'b0, src: SRC_DEF, filt_en: 1'b0, tau: TAU_DEF, rng_en: 1'b0,
        in_min: '0, in_max: '0, cyc: CYC_DEF, rnd: RND_FLOAT, used: '0,
        px: '{1: SCALE, default: '0}, py: '0
    };

endpackage : aisc_pkg

// [rtl/aisc_curves.sv]
// What this block does
// - Master enable, off after reset; while off no curve processes or publishes.
// - Each curve has its own enable gating input sampling and curve evaluation.
// - Each curve picks one source measurement; default is first card current input.
// - Smoothing optional per curve, off by default; time constant in 5 ms steps.
// - Smoothing is a first-order low-pass average over the input.
// - Per-curve minimum and maximum input limits, default zero, 0.00001 resolution.
// - With range check on, flag is set while input below minimum or above maximum.
// - Each curve's out-of-range flag is a binary output.
// - On input signal loss the last valid input value is held.
// - Input refreshed once per update cycle, 5 ms steps, default 150 ms.
// - Output is fixed point or integer by floor, ceiling or nearest rounding.
// - Curve is input/output point pairs; two points by default.
// - Extra points individually enabled, up to 20 points per curve.
// - Input received and resulting output are readable per curve.
`timescale 1ns/100ps
module aisc_curves
    import aisc_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic scale_en,
    input wire aisc_cfg_t cfg [NCURVE],
    input wire aisc_val_t meas_val [NSRC],
    input wire logic [NSRC-1:0] meas_ok,
    output logic [NCURVE-1:0] curve_input_out_of_range,
    output logic [NCURVE-1:0] curve_out_upd,
    output aisc_val_t curve_in_val [NCURVE],
    output aisc_val_t curve_out_val [NCURVE]
);

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic aisc_val_t fl_fn(input aisc_val_t v);
        aisc_val_t q;
        q = v / SCALE;
        if (v - q * SCALE < 0) begin
            q = q - 44'h00000000001;
        end
        return q * SCALE;
    endfunction : fl_fn

    function automatic aisc_val_t rnd_fn(input aisc_val_t v, input aisc_rnd_t m);
        case (m)
            RND_FLOOR: rnd_fn = fl_fn(v);
            RND_CEIL: rnd_fn = -fl_fn(-v);
            RND_NEAR: rnd_fn = fl_fn(v + HALF);
            default: rnd_fn = v;
        endcase
    endfunction : rnd_fn

    aisc_st_t st_q;
    logic [3:0] cur_q, pick;
    logic pick_ok;
    logic [4:0] k_q, prev_q, prev2_q, lo_q, hi_q;
    logic found_q;
    logic [31:0] pre_q;
    logic tick_q;
    logic [10:0] cnt_q [NCURVE];
    logic [NCURVE-1:0] pend_q, oor_q, upd_q;
    aisc_val_t in_q [NCURVE];
    aisc_val_t out_q [NCURVE];
    aisc_cfg_t c;
    logic [5:0] sidx;
    logic ok_w, oor_w;
    aisc_val_t raw_w, in_cur_w, out_cur_w, nv_w, res_w, px_k, xl_w, xh_w, yl_w, yh_w;
    aisc_wide_t fnum, fden, inum, iden;

    // ************************************************************
    // Update-cycle timebase and per-curve scheduling
    // ************************************************************
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pre_q <= '0;
            tick_q <= 1'b0;
        end else if (ce) begin
            tick_q <= (pre_q == 32'(TICK_CYCLES - 1));
            pre_q <= (pre_q == 32'(TICK_CYCLES - 1)) ? '0 : pre_q + 32'h00000001;
        end
    end

    always_comb begin
        pick_ok = 1'b0;
        pick = '0;
        for (int i = NCURVE - 1; i >= 0; i--) begin
            if (pend_q[i]) begin
                pick_ok = 1'b1;
                pick = 4'(i);
            end
        end
    end

    // A pick in the same cycle as a new period keeps the request: set wins
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pend_q <= '0;
            for (int i = 0; i < NCURVE; i++) begin
                cnt_q[i] <= '0;
            end
        end else if (ce) begin
            for (int i = 0; i < NCURVE; i++) begin
                if (!(scale_en && cfg[i].en)) begin
                    cnt_q[i] <= '0;
                    pend_q[i] <= 1'b0;
                end else begin
                    if (tick_q) begin
                        cnt_q[i] <= (cnt_q[i] + 11'h001 >= cfg[i].cyc) ? '0 : cnt_q[i] + 11'h001;
                    end
                    pend_q[i] <= (tick_q && cnt_q[i] + 11'h001 >= cfg[i].cyc)
                        || (pend_q[i] && !(st_q == ST_IDLE && pick_ok && pick == 4'(i)));
                end
            end
        end
    end

    // ************************************************************
    // Current curve datapath
    // ************************************************************
    always_comb begin
        c = cfg[cur_q];
        sidx = (c.src < 6'(NSRC)) ? c.src : SRC_DEF;
        ok_w = (c.src < 6'(NSRC)) && meas_ok[sidx];
        raw_w = meas_val[sidx];
        in_cur_w = in_q[cur_q];
        out_cur_w = out_q[cur_q];
        fnum = (aisc_wide_t'(raw_w) - aisc_wide_t'(in_cur_w)) * aisc_wide_t'(c.cyc);
        fden = aisc_wide_t'(c.cyc) + aisc_wide_t'(c.tau);
        // Discrete first-order step: alpha = T_update / (T_update + tau)
        if (c.filt_en && fden != '0) begin
            nv_w = in_cur_w + aisc_val_t'(fnum / fden);
        end else begin
            nv_w = raw_w;
        end
        if (!ok_w) begin
            nv_w = in_cur_w;
        end
        oor_w = c.rng_en && (nv_w < c.in_min || nv_w > c.in_max);
        px_k = c.px[k_q];
        xl_w = c.px[lo_q];
        xh_w = c.px[hi_q];
        yl_w = c.py[lo_q];
        yh_w = c.py[hi_q];
        inum = (aisc_wide_t'(in_cur_w) - aisc_wide_t'(xl_w))
            * (aisc_wide_t'(yh_w) - aisc_wide_t'(yl_w));
        iden = aisc_wide_t'(xh_w) - aisc_wide_t'(xl_w);
        // Coincident points would divide by zero; fall back to the lower output
        res_w = rnd_fn((iden == '0) ? yl_w : yl_w + aisc_val_t'(inum / iden), c.rnd);
    end

    // ************************************************************
    // Evaluation sequencer
    // ************************************************************
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= ST_IDLE;
            cur_q <= '0;
            k_q <= '0;
            prev_q <= '0;
            prev2_q <= '0;
            lo_q <= '0;
            hi_q <= 5'h01;
            found_q <= 1'b0;
        end else if (ce) begin
            if (!scale_en) begin
                st_q <= ST_IDLE;
            end else begin
                case (st_q)
                    ST_IDLE: begin
                        if (pick_ok) begin
                            cur_q <= pick;
                            st_q <= ST_LOAD;
                        end
                    end
                    ST_LOAD: begin
                        k_q <= 5'h01;
                        prev_q <= '0;
                        prev2_q <= '0;
                        lo_q <= '0;
                        hi_q <= 5'h01;
                        found_q <= 1'b0;
                        st_q <= ST_SEG;
                    end
                    ST_SEG: begin
                        // Points must be entered with rising input values
                        if (!found_q && (k_q == 5'h01 || c.used[k_q])) begin
                            if (px_k >= in_cur_w) begin
                                lo_q <= prev_q;
                                hi_q <= k_q;
                                found_q <= 1'b1;
                            end else begin
                                prev2_q <= prev_q;
                                prev_q <= k_q;
                            end
                        end
                        if (k_q == 5'(NPTS - 1)) begin
                            st_q <= ST_FIX;
                        end else begin
                            k_q <= k_q + 5'h01;
                        end
                    end
                    ST_FIX: begin
                        // Above the last point: extend the last segment
                        if (!found_q) begin
                            lo_q <= prev2_q;
                            hi_q <= prev_q;
                        end
                        st_q <= ST_CALC;
                    end
                    ST_CALC: st_q <= ST_IDLE;
                    default: st_q <= ST_IDLE;
                endcase
            end
        end
    end

    // ************************************************************
    // Published values
    // ************************************************************
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            oor_q <= '0;
            upd_q <= '0;
            for (int i = 0; i < NCURVE; i++) begin
                in_q[i] <= '0;
                out_q[i] <= '0;
            end
        end else if (ce) begin
            upd_q <= '0;
            for (int i = 0; i < NCURVE; i++) begin
                if (!cfg[i].en || !cfg[i].rng_en) begin
                    oor_q[i] <= 1'b0;
                end
            end
            if (scale_en && st_q == ST_LOAD) begin
                in_q[cur_q] <= nv_w;
                oor_q[cur_q] <= oor_w;
            end
            if (scale_en && st_q == ST_CALC) begin
                out_q[cur_q] <= res_w;
                upd_q[cur_q] <= 1'b1;
            end
        end
    end

    assign curve_input_out_of_range = oor_q;
    assign curve_out_upd = upd_q;
    assign curve_in_val = in_q;
    assign curve_out_val = out_q;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    property p_master_off;
        (ce && !scale_en) |=> (st_q == ST_IDLE) && (upd_q == '0);
    endproperty
    a_master_off: assert property (p_master_off) else $error("Curve active while disabled");
    property p_pick_en;
        (ce && scale_en && st_q == ST_IDLE && pick_ok) |-> cfg[pick].en;
    endproperty
    a_pick_en: assert property (p_pick_en) else $error("Disabled curve scheduled");
    property p_raw_load;
        (ce && scale_en && st_q == ST_LOAD && ok_w && !c.filt_en) |=> in_cur_w == $past(raw_w);
    endproperty
    a_raw_load: assert property (p_raw_load) else $error("Raw input not taken");
    property p_hold;
        (ce && st_q == ST_LOAD && !ok_w) |=> in_cur_w == $past(in_cur_w);
    endproperty
    a_hold: assert property (p_hold) else $error("Input not held on loss");
    property p_filt;
        (ce && scale_en && st_q == ST_LOAD && ok_w && c.filt_en && raw_w > in_cur_w)
            |=> in_cur_w >= $past(in_cur_w) && in_cur_w <= $past(raw_w);
    endproperty
    a_filt: assert property (p_filt) else $error("Filter overshoot");
    property p_range;
        (st_q == ST_SEG && k_q == 5'h01 && c.en)
            |-> oor_q[cur_q] == (c.rng_en && (in_cur_w < c.in_min || in_cur_w > c.in_max));
    endproperty
    a_range: assert property (p_range) else $error("Range flag wrong");
    property p_period;
        (ce && tick_q && scale_en && cfg[0].en && cnt_q[0] + 11'h001 >= cfg[0].cyc)
            |=> pend_q[0] || st_q == ST_LOAD;
    endproperty
    a_period: assert property (p_period) else $error("Update cycle missed");
    property p_seg_len;
        (ce && st_q == ST_LOAD && scale_en) ##1 1'b1 |-> (st_q == ST_SEG || !scale_en)[*8];
    endproperty
    a_seg_len: assert property (p_seg_len) else $error("Point walk too short");
    property p_round;
        (ce && scale_en && st_q == ST_CALC && c.rnd != RND_FLOAT)
            |=> out_cur_w % SCALE == 0;
    endproperty
    a_round: assert property (p_round) else $error("Integer output not whole");
    property p_interp;
        (ce && scale_en && st_q == ST_CALC && c.rnd == RND_FLOAT && in_cur_w == xl_w)
            |=> out_cur_w == $past(yl_w);
    endproperty
    a_interp: assert property (p_interp) else $error("Interpolation at point wrong");

endmodule : aisc_curves

// [bench/aisc_src_model.sv]
`timescale 1ns/100ps
// ************************************************************
// Acquisition channels on the option cards
// ************************************************************
module aisc_src_model
    import aisc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic set_wr,
    input wire logic [5:0] set_idx,
    input wire aisc_val_t set_val,
    input wire logic set_ok,
    output aisc_val_t meas_val [NSRC],
    output logic [NSRC-1:0] meas_ok
);
    aisc_val_t val_q [NSRC];

    // One flat list of sources, current inputs first
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            meas_ok <= '1;
            val_q <= '{default: '0};
        end else if (set_wr) begin
            val_q[set_idx] <= set_val;
            meas_ok[set_idx] <= set_ok;
        end
    end

    // A broken signal shows garbage, so a held value cannot come from the wire
    always_comb begin
        for (int i = 0; i < NSRC; i++) begin
            meas_val[i] = meas_ok[i] ? val_q[i] : ~val_q[i];
        end
    end
endmodule : aisc_src_model

// [bench/tb_top.sv]
`timescale 1ns/100ps
module tb_top
    import aisc_pkg::*;
;
    typedef struct packed {
        logic [3:0] n;
        aisc_val_t iv;
        aisc_val_t ov;
        logic of;
    } aisc_exp_t;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic scale_en = 1'b0;
    logic ce = 1'b1;
    logic set_wr = 1'b0;
    logic set_ok = 1'b1;
    logic [5:0] set_idx = '0;
    aisc_val_t set_val = '0;
    aisc_cfg_t cfg [NCURVE] = '{default: CFG_DEF};
    aisc_val_t meas_val [NSRC];
    logic [NSRC-1:0] meas_ok;
    logic [NCURVE-1:0] oor;
    logic [NCURVE-1:0] upd;
    aisc_val_t in_val [NCURVE];
    aisc_val_t out_val [NCURVE];
    aisc_exp_t expq [$];
    aisc_cfg_t c;
    int cur = 0;
    int fails = 0;
    int check_count = 0;
    int quiet = 0;
    int g;
    logic [15:0] lfsr = 16'h0038;

    always #50 sys_clk = ~sys_clk;

    aisc_src_model src (.sys_clk(sys_clk), .nrst(nrst), .set_wr(set_wr), .set_idx(set_idx),
        .set_val(set_val), .set_ok(set_ok), .meas_val(meas_val), .meas_ok(meas_ok));
    // Short timebase keeps a 5 ms step at 4 clocks
    aisc_curves #(.TICK_CYCLES(4)) dut (.sys_clk(sys_clk), .nrst(nrst), .ce(ce),
        .scale_en(scale_en), .cfg(cfg), .meas_val(meas_val), .meas_ok(meas_ok),
        .curve_input_out_of_range(oor), .curve_out_upd(upd), .curve_in_val(in_val),
        .curve_out_val(out_val));

    // ************************************************************
    // Helpers
    // ************************************************************
    task report(input string m);
        fails++;
        $display("mismatch %0t %s", $time, m);
    endtask : report

    task tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : tally_and_finish

    task tick(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask : tick

    // Positive values only, which is all the scenarios use
    function automatic aisc_val_t exp_out(aisc_cfg_t f, aisc_val_t x);
        int lo = 0;
        int pv = 0;
        int hi = -1;
        aisc_wide_t y;
        logic [NPTS-1:0] on;
        on = f.used | 20'h00003;
        for (int k = 0; k < NPTS; k++) begin
            if (on[k] && hi < 0) begin
                if (f.px[k] >= x) hi = k;
                else begin
                    pv = lo;
                    lo = k;
                end
            end
        end
        if (hi < 0) begin
            hi = lo;
            lo = pv;
        end
        if (hi == 0) hi = 1;
        if (f.px[hi] == f.px[lo]) return f.py[lo];
        y = aisc_wide_t'(x - f.px[lo]) * aisc_wide_t'(f.py[hi] - f.py[lo]);
        y = y / aisc_wide_t'(f.px[hi] - f.px[lo]) + f.py[lo];
        case (f.rnd)
            RND_FLOOR: y = y / SCALE * SCALE;
            RND_CEIL: y = (y + SCALE - 1) / SCALE * SCALE;
            RND_NEAR: y = (y + HALF) / SCALE * SCALE;
            default: y = y;
        endcase
        return aisc_val_t'(y);
    endfunction : exp_out

    // Abort anything in flight, load the source, then enable one curve
    task apply(input aisc_val_t raw, input logic ok);
        scale_en = 1'b0;
        cfg = '{default: CFG_DEF};
        set_idx = c.src;
        set_val = raw;
        set_ok = ok;
        set_wr = 1'b1;
        tick(1);
        set_wr = 1'b0;
        cfg[cur] = c;
        scale_en = 1'b1;
    endtask : apply

    task expect_in(input aisc_val_t iv, input logic of);
        expq.push_back('{n: cur[3:0], iv: iv, ov: exp_out(c, iv), of: of});
    endtask : expect_in

    task drain;
        for (int w = 0; w < 3000 && expq.size() > 0; w++) tick(1);
        if (expq.size() > 0) begin
            report("no curve update");
            tally_and_finish;
        end
    endtask : drain

    // ************************************************************
    // Result watcher
    // ************************************************************
    always @(negedge sys_clk) begin
        aisc_exp_t e;
        if (quiet != 0) begin
            check_count++;
            if (upd !== '0) report("update while disabled");
        end
        for (int n = 0; n < NCURVE; n++) begin
            if (upd[n] === 1'b1 && expq.size() > 0) begin
                e = expq.pop_front();
                check_count++;
                if (e.n != n || in_val[n] !== e.iv || out_val[n] !== e.ov ||
                        oor[n] !== e.of) report("curve result differs");
            end
        end
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        tick(6);
        nrst = 1'b1;
        tick(1);
        c = CFG_DEF;
        c.en = 1'b1;
        c.cyc = 11'h001;
        c.px[1] = 44'h00000f4240;
        c.py[1] = 44'h00001e8480;
        cfg[0] = c;
        quiet = 1;
        tick(100);
        cfg = '{default: CFG_DEF};
        scale_en = 1'b1;
        tick(100);
        quiet = 0;
        // Tau of 15 ms is well over twice a 5 ms ripple
        c.filt_en = 1'b1;
        c.tau = 20'h00003;
        apply(44'h0000061a80, 1'b1);
        expect_in(44'h00000186a0, 1'b0);
        expect_in(44'h000002ab98, 1'b0);
        drain();
        c.filt_en = 1'b0;
        c.rng_en = 1'b1;
        c.in_min = SCALE;
        c.in_max = 44'h00000493e0;
        for (int i = 0; i < 4; i++) begin
            c.src = 6'(i * 15);
            apply(i == 0 ? 44'h000000c350 : i == 1 ? SCALE : i == 2 ? c.in_max : 44'h00000493e1,
                1'b1);
            expect_in(src.val_q[c.src], i == 0 || i == 3);
            drain();
        end
        apply(44'h0000000001, 1'b0);
        expect_in(44'h00000493e1, 1'b1);
        drain();
        c.rng_en = 1'b0;
        for (int i = 0; i < 8; i++) begin
            lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
            c.rnd = aisc_rnd_t'(i[1:0]);
            apply(i < 4 ? 44'h000001e848 : aisc_val_t'(lfsr) * 16, 1'b1);
            expect_in(src.val_q[c.src], 1'b0);
            drain();
        end
        cur = 9;
        c.rnd = RND_FLOAT;
        c.used[2] = 1'b1;
        c.px[2] = 44'h00001e8480;
        c.py[2] = 44'h00001e8480;
        for (int i = 1; i < 6; i += 2) begin
            apply(aisc_val_t'(i) * 44'h000007a120, 1'b1);
            expect_in(aisc_val_t'(i) * 44'h000007a120, 1'b0);
            drain();
        end
        c.cyc = 11'h00a;
        apply(SCALE, 1'b1);
        for (int w = 0; w < 500 && upd[cur] !== 1'b1; w++) tick(1);
        tick(1);
        for (g = 1; g < 500 && upd[cur] !== 1'b1; g++) tick(1);
        check_count++;
        if (g != 40) report("update period wrong");
        check_count++;
        if (in_val[cur] !== SCALE || out_val[cur] !== exp_out(c, SCALE)) report("readback");
        // Clock enable low must freeze the timebase, so no update may appear
        tick(1);
        ce = 1'b0;
        quiet = 1;
        tick(200);
        quiet = 0;
        ce = 1'b1;
        check_count++;
        if (in_val[cur] !== SCALE) report("state moved while frozen");
        tally_and_finish;
    end
endmodule : tb_top
